// ==== hw/port_ctl_regs.sv ====
// register bank and port state control of the cluster port adapter
// Operation
// RULE1: any write in the control range triggers its operation; data ignored.
// RULE2: reads of write-only control registers are undefined; here zero.
// RULE3: command queue kick writes start processing of queue 0 to 3.
// RULE4: status release write frees the lock on the port status register.
// RULE5: enable write moves the port to the enabled state.
// RULE6: disable write disables port, sets disable-done, requests interrupt; here disable-done and interrupt only from enabled.
// RULE7: initialize write initializes, disables port, sets init-done, interrupts.
// RULE8: initialize while enabled drops to disabled and loses processing state.
// RULE9: host writes datagram free notify when inserting into empty queue.
// RULE10: host writes message free notify when inserting into empty queue.
// RULE11: timer force write expires sanity timer if enabled/disabled and timer on.
// RULE12: timer reload write restarts boot and sanity timers.
// RULE13: node count code: 16, 32, 64, 128, 224; upper codes reserved.
// RULE14: quiet slot code: 0 means 7, 1 means 10; others reserved.
// RULE15: error status: misc code high half, structure code low half.
// RULE16: vector register: priority 19:16, vector 15:2, other bits zero.
// RULE17: interrupt destination holds 16 bits, upper half reads zero.
// RULE18: parameters report buffer length, extension, ack, arbitration, header flags.
// RULE19: parameter extension: subnode 15:8, state block length 7:0.
// RULE20: serial number: plant in 31:28, number in 27:0.
// RULE21: queue block base holds address 39:9 in 30:0, bit 31 zero.
// RULE22: port leaves uninitialized on initialize write or boot timer expiry.
// RULE23: status release clears message-free-empty and response-available flags.
// RULE24: registers decode from the node base, one aligned longword each.
`timescale 1ns/100ps
module port_ctl_regs #(
  parameter int BOOT_CYC = port_ctl_pkg::BOOT_CYCLES,
  parameter int SANITY_CYC = port_ctl_pkg::SANITY_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register access from the node base
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rd_valid,
  // microcode side status and errors
  input wire logic sanity_timer_en,
  input wire logic msg_free_empty_set,
  input wire logic rsp_avail_set,
  input wire logic [15:0] misc_err_code,
  input wire logic [15:0] structure_fault,
  input wire logic [31:0] fail_addr,
  // port operations
  output logic [3:0] cmd_queue_kick,
  output logic datagram_free_kick,
  output logic message_free_kick,
  output logic proc_state_lost,
  output logic irq_req,
  output logic status_locked,
  output logic [2:0] port_state,
  output logic [31:0] port_status_reg,
  output logic [30:0] queue_block_base,
  output logic [15:0] irq_dest,
  output logic [3:0] irq_priority,
  output logic [13:0] irq_vector
);
  port_ctl_pkg::port_state_t state_r;
  port_ctl_pkg::port_state_t state_nxt;
  logic wr_qbb, wr_idr, wr_ivr;
  logic wr_kick0, wr_kick1, wr_kick2, wr_kick3;
  logic wr_release, wr_enable, wr_disable, wr_init;
  logic wr_dfree, wr_mfree, wr_force, wr_reload;
  logic boot_expire, sanity_expire, force_expire;
  logic enter_enabled, enter_disabled, leave_disabled, enter_uninit;
  logic init_done_set, disable_done_set, timer_exp_set;
  logic [31:0] boot_cnt_r;
  logic [31:0] sanity_cnt_r;
  logic [30:0] qbb_r;
  logic [15:0] idr_r;
  logic [3:0] ipl_r;
  logic [13:0] ivec_r;
  logic f_timer_r, f_init_r, f_dis_r, f_mfe_r, f_rsp_r;
  logic lock_r;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  logic rd_valid_r;
  logic [3:0] kick_r;
  logic dfree_r, mfree_r, lost_r, irq_r;

  // address decode, one longword per register [RULE24]
  always_comb begin
    wr_qbb = reg_wr_en && reg_addr == port_ctl_pkg::OFS_QUEUE_BLOCK_BASE;
    wr_idr = reg_wr_en && reg_addr == port_ctl_pkg::OFS_INTERRUPT_DESTINATION;
    wr_ivr = reg_wr_en && reg_addr == port_ctl_pkg::OFS_INTERRUPT_VECTOR_LEVEL;
    // write-only range: the access alone acts, reg_wdata unused here [RULE1]
    wr_kick0 = reg_wr_en && reg_addr == port_ctl_pkg::OFS_CMD_QUEUE0_KICK;
    wr_kick1 = reg_wr_en && reg_addr == port_ctl_pkg::OFS_CMD_QUEUE1_KICK;
    wr_kick2 = reg_wr_en && reg_addr == port_ctl_pkg::OFS_CMD_QUEUE2_KICK;
    wr_kick3 = reg_wr_en && reg_addr == port_ctl_pkg::OFS_CMD_QUEUE3_KICK;
    wr_release = reg_wr_en && reg_addr == port_ctl_pkg::OFS_STATUS_RELEASE;
    wr_enable = reg_wr_en && reg_addr == port_ctl_pkg::OFS_ENABLE_TRIGGER;
    wr_disable = reg_wr_en && reg_addr == port_ctl_pkg::OFS_DISABLE_TRIGGER;
    wr_init = reg_wr_en && reg_addr == port_ctl_pkg::OFS_INITIALIZE_TRIGGER;
    wr_dfree = reg_wr_en && reg_addr == port_ctl_pkg::OFS_DATAGRAM_FREE_NOTIFY;
    wr_mfree = reg_wr_en && reg_addr == port_ctl_pkg::OFS_MESSAGE_FREE_NOTIFY;
    wr_force = reg_wr_en && reg_addr == port_ctl_pkg::OFS_TIMER_FORCE_EXPIRE;
    wr_reload = reg_wr_en && reg_addr == port_ctl_pkg::OFS_TIMER_RELOAD;
  end

  // timer expiries and forced expiry
  always_comb begin
    boot_expire = state_r == port_ctl_pkg::ST_UNINIT && boot_cnt_r == 32'h0 && !wr_reload;
    // forced expiry only counts in enabled or disabled with the timer on [RULE11]
    force_expire = wr_force && sanity_timer_en && state_r != port_ctl_pkg::ST_UNINIT;
    sanity_expire = sanity_timer_en && state_r != port_ctl_pkg::ST_UNINIT
                    && sanity_cnt_r == 32'h0 && !wr_reload;
  end

  // next port state; sanity or forced expiry beats the register triggers of the same cycle, an initialize write beats boot expiry
  always_comb begin
    state_nxt = state_r;
    if (force_expire || sanity_expire) begin
      state_nxt = port_ctl_pkg::ST_UNINIT;
    end else if (wr_init) begin
      state_nxt = port_ctl_pkg::ST_DISABLED; // [RULE7] [RULE8] [RULE22]
    end else if (boot_expire) begin
      state_nxt = port_ctl_pkg::ST_DISABLED; // [RULE22]
    end else if (wr_disable && state_r != port_ctl_pkg::ST_UNINIT) begin
      state_nxt = port_ctl_pkg::ST_DISABLED; // [RULE6]
    end else if (wr_enable && state_r == port_ctl_pkg::ST_DISABLED) begin
      state_nxt = port_ctl_pkg::ST_ENABLED; // [RULE5]
    end
  end

  always_comb begin
    enter_enabled = state_nxt == port_ctl_pkg::ST_ENABLED && state_r != port_ctl_pkg::ST_ENABLED;
    enter_disabled = state_nxt == port_ctl_pkg::ST_DISABLED && state_r != port_ctl_pkg::ST_DISABLED;
    leave_disabled = state_r == port_ctl_pkg::ST_DISABLED && state_nxt != port_ctl_pkg::ST_DISABLED;
    enter_uninit = force_expire || sanity_expire;
    init_done_set = (wr_init || boot_expire) && !enter_uninit; // [RULE7]
    disable_done_set = wr_disable && state_r == port_ctl_pkg::ST_ENABLED
                       && !enter_uninit && !wr_init; // [RULE6]
    timer_exp_set = enter_uninit;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= port_ctl_pkg::ST_UNINIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // boot timer runs only while uninitialized
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boot_cnt_r <= 32'(BOOT_CYC - 1);
    end else if (wr_reload || state_r != port_ctl_pkg::ST_UNINIT) begin
      boot_cnt_r <= 32'(BOOT_CYC - 1); // [RULE12]
    end else if (boot_cnt_r != 32'h0) begin
      boot_cnt_r <= boot_cnt_r - 32'h1;
    end
  end

  // sanity timer held at its start value while suspended
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sanity_cnt_r <= 32'(SANITY_CYC - 1);
    end else if (wr_reload || !sanity_timer_en || state_nxt == port_ctl_pkg::ST_UNINIT) begin
      sanity_cnt_r <= 32'(SANITY_CYC - 1); // [RULE12]
    end else if (sanity_cnt_r != 32'h0) begin
      sanity_cnt_r <= sanity_cnt_r - 32'h1;
    end
  end

  // port status flags; every hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      f_timer_r <= 1'h0;
    end else if (timer_exp_set) begin
      f_timer_r <= 1'h1;
    end else if (init_done_set) begin
      f_timer_r <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      f_init_r <= 1'h0;
    end else if (init_done_set) begin
      f_init_r <= 1'h1; // [RULE7]
    end else if (enter_enabled) begin
      f_init_r <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      f_dis_r <= 1'h0;
    end else if (disable_done_set) begin
      f_dis_r <= 1'h1; // [RULE6]
    end else if (leave_disabled) begin
      f_dis_r <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      f_mfe_r <= 1'h0;
      f_rsp_r <= 1'h0;
    end else begin
      if (msg_free_empty_set) begin
        f_mfe_r <= 1'h1;
      end else if (wr_release) begin
        f_mfe_r <= 1'h0; // [RULE23]
      end
      if (rsp_avail_set) begin
        f_rsp_r <= 1'h1;
      end else if (wr_release) begin
        f_rsp_r <= 1'h0; // [RULE23]
      end
    end
  end

  // status lock: taken with each interrupt, held until host releases
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_r <= 1'h0;
    end else if (irq_r) begin
      lock_r <= 1'h1;
    end else if (wr_release) begin
      lock_r <= 1'h0; // [RULE4]
    end
  end

  // interrupt request pulse one cycle after the causing event
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_r <= 1'h0;
    end else begin
      irq_r <= init_done_set || disable_done_set || timer_exp_set
               || msg_free_empty_set || rsp_avail_set; // [RULE6] [RULE7] [RULE11]
    end
  end

  // operation pulses toward the port engine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      kick_r <= 4'h0;
      dfree_r <= 1'h0;
      mfree_r <= 1'h0;
      lost_r <= 1'h0;
    end else begin
      kick_r <= {wr_kick3, wr_kick2, wr_kick1, wr_kick0}; // [RULE3]
      dfree_r <= wr_dfree; // [RULE9]
      mfree_r <= wr_mfree; // [RULE10]
      // enabled port re-initialized: engine must drop in-flight work [RULE8]
      lost_r <= (wr_init && state_r == port_ctl_pkg::ST_ENABLED) || enter_uninit;
    end
  end

  // software-written registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      qbb_r <= 31'h0;
      idr_r <= 16'h0;
      ipl_r <= 4'h0;
      ivec_r <= 14'h0;
    end else begin
      if (wr_qbb) begin
        qbb_r <= reg_wdata[30:0]; // [RULE21]
      end
      if (wr_idr) begin
        idr_r <= reg_wdata[15:0]; // [RULE17]
      end
      if (wr_ivr) begin
        ipl_r <= reg_wdata[19:16]; // [RULE16]
        ivec_r <= reg_wdata[15:2];
      end
    end
  end

  // read mux; write-only and unmapped offsets read as zero [RULE2]
  always_comb begin
    rdata_nxt = 32'h0;
    case (reg_addr)
      port_ctl_pkg::OFS_QUEUE_BLOCK_BASE: rdata_nxt = {1'h0, qbb_r}; // [RULE21]
      port_ctl_pkg::OFS_ERROR_STATUS_CODES: rdata_nxt = {misc_err_code, structure_fault}; // [RULE15]
      port_ctl_pkg::OFS_FAILING_ADDRESS: rdata_nxt = fail_addr;
      port_ctl_pkg::OFS_PORT_PARAMETERS: begin
        rdata_nxt[port_ctl_pkg::PPR_NODE_COUNT_LSB +: 3] = port_ctl_pkg::NODE_COUNT_CODE; // [RULE13]
        rdata_nxt[port_ctl_pkg::PPR_PKT_BUF_LSB +: 13] = port_ctl_pkg::PKT_BUF_LEN; // [RULE18]
        rdata_nxt[port_ctl_pkg::PPR_EXT_PRESENT] = port_ctl_pkg::PARAM_EXT_PRESENT;
        rdata_nxt[port_ctl_pkg::PPR_EXT_ACK] = port_ctl_pkg::EXT_ACK_TIMEOUT;
        rdata_nxt[port_ctl_pkg::PPR_DIS_ARB] = port_ctl_pkg::DISABLE_ARB;
        rdata_nxt[port_ctl_pkg::PPR_EXT_HDR] = port_ctl_pkg::EXT_HEADER;
        rdata_nxt[port_ctl_pkg::PPR_QUIET_SLOT_LSB +: 3] = port_ctl_pkg::QUIET_SLOT_CODE; // [RULE14]
      end
      port_ctl_pkg::OFS_SERIAL_NUMBER:
        rdata_nxt = {port_ctl_pkg::FACTORY_PLANT, port_ctl_pkg::FACTORY_NUMBER}; // [RULE20]
      port_ctl_pkg::OFS_INTERRUPT_DESTINATION: rdata_nxt = {16'h0, idr_r}; // [RULE17]
      port_ctl_pkg::OFS_INTERRUPT_VECTOR_LEVEL: rdata_nxt = {12'h0, ipl_r, ivec_r, 2'h0}; // [RULE16]
      port_ctl_pkg::OFS_PARAMETER_EXTENSION:
        rdata_nxt = {16'h0, port_ctl_pkg::SUBNODE_NUMBER, port_ctl_pkg::STATE_BLOCK_LEN}; // [RULE19]
      default: rdata_nxt = 32'h0;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0;
      rd_valid_r <= 1'h0;
    end else begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // status word: summary bit follows any error-class flag
  always_comb begin
    port_status_reg = 32'h0;
    port_status_reg[port_ctl_pkg::PSR_UNINIT] = state_r == port_ctl_pkg::ST_UNINIT;
    port_status_reg[port_ctl_pkg::PSR_TIMER_EXP] = f_timer_r;
    port_status_reg[port_ctl_pkg::PSR_INIT_DONE] = f_init_r;
    port_status_reg[port_ctl_pkg::PSR_DISABLE_DONE] = f_dis_r;
    port_status_reg[port_ctl_pkg::PSR_MSG_FREE_EMPTY] = f_mfe_r;
    port_status_reg[port_ctl_pkg::PSR_RSP_AVAIL] = f_rsp_r;
    port_status_reg[port_ctl_pkg::PSR_SUMMARY] = state_r == port_ctl_pkg::ST_UNINIT || f_timer_r
                                                 || f_init_r || f_dis_r || f_mfe_r;
  end

  assign reg_rdata = rdata_r;
  assign reg_rd_valid = rd_valid_r;
  assign cmd_queue_kick = kick_r;
  assign datagram_free_kick = dfree_r;
  assign message_free_kick = mfree_r;
  assign proc_state_lost = lost_r;
  assign irq_req = irq_r;
  assign status_locked = lock_r;
  assign port_state = state_r;
  assign queue_block_base = qbb_r;
  assign irq_dest = idr_r;
  assign irq_priority = ipl_r;
  assign irq_vector = ivec_r;
endmodule

// ==== shared/port_ctl_pkg.sv ====
// constants for the cluster port control register bank
package port_ctl_pkg;
  // register offsets from the node base
  localparam logic [15:0] OFS_QUEUE_BLOCK_BASE = 16'h1000;
  localparam logic [15:0] OFS_ERROR_STATUS_CODES = 16'h1008;
  localparam logic [15:0] OFS_FAILING_ADDRESS = 16'h100c;
  localparam logic [15:0] OFS_PORT_PARAMETERS = 16'h1010;
  localparam logic [15:0] OFS_SERIAL_NUMBER = 16'h1014;
  localparam logic [15:0] OFS_INTERRUPT_DESTINATION = 16'h1018;
  localparam logic [15:0] OFS_INTERRUPT_VECTOR_LEVEL = 16'h1020;
  localparam logic [15:0] OFS_CMD_QUEUE0_KICK = 16'h1028;
  localparam logic [15:0] OFS_CMD_QUEUE1_KICK = 16'h102c;
  localparam logic [15:0] OFS_CMD_QUEUE2_KICK = 16'h1030;
  localparam logic [15:0] OFS_CMD_QUEUE3_KICK = 16'h1034;
  localparam logic [15:0] OFS_STATUS_RELEASE = 16'h1038;
  localparam logic [15:0] OFS_ENABLE_TRIGGER = 16'h103c;
  localparam logic [15:0] OFS_DISABLE_TRIGGER = 16'h1040;
  localparam logic [15:0] OFS_INITIALIZE_TRIGGER = 16'h1044;
  localparam logic [15:0] OFS_DATAGRAM_FREE_NOTIFY = 16'h1048;
  localparam logic [15:0] OFS_MESSAGE_FREE_NOTIFY = 16'h104c;
  localparam logic [15:0] OFS_TIMER_FORCE_EXPIRE = 16'h1050;
  localparam logic [15:0] OFS_TIMER_RELOAD = 16'h1054;
  localparam logic [15:0] OFS_PARAMETER_EXTENSION = 16'h1058;
  // write-only control range
  localparam logic [15:0] OFS_WO_FIRST = 16'h1028;
  localparam logic [15:0] OFS_WO_LAST = 16'h1054;

  // port status flag positions
  localparam int PSR_SUMMARY = 31;
  localparam int PSR_UNINIT = 10;
  localparam int PSR_TIMER_EXP = 6;
  localparam int PSR_INIT_DONE = 3;
  localparam int PSR_DISABLE_DONE = 2;
  localparam int PSR_MSG_FREE_EMPTY = 1;
  localparam int PSR_RSP_AVAIL = 0;

  // port parameter fields, fixed by the build
  localparam logic [2:0] NODE_COUNT_CODE = 3'h4;
  localparam logic [12:0] PKT_BUF_LEN = 13'h1000;
  localparam logic PARAM_EXT_PRESENT = 1'h1;
  localparam logic EXT_ACK_TIMEOUT = 1'h0;
  localparam logic DISABLE_ARB = 1'h0;
  localparam logic EXT_HEADER = 1'h0;
  localparam logic [2:0] QUIET_SLOT_CODE = 3'h0;
  localparam int PPR_NODE_COUNT_LSB = 29;
  localparam int PPR_PKT_BUF_LSB = 16;
  localparam int PPR_EXT_PRESENT = 15;
  localparam int PPR_EXT_ACK = 13;
  localparam int PPR_DIS_ARB = 12;
  localparam int PPR_EXT_HDR = 11;
  localparam int PPR_QUIET_SLOT_LSB = 8;

  // parameter extension fields
  localparam logic [7:0] SUBNODE_NUMBER = 8'h00;
  localparam logic [7:0] STATE_BLOCK_LEN = 8'h00;

  // serial number fields, values arbitrary
  localparam logic [3:0] FACTORY_PLANT = 4'h1;
  localparam logic [27:0] FACTORY_NUMBER = 28'h0000001;

  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BOOT_TIMEOUT_MS = 100;
  localparam int SANITY_TIMEOUT_MS = 1000;
  localparam int BOOT_CYCLES = BOOT_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SANITY_CYCLES = SANITY_TIMEOUT_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    ST_UNINIT = 3'h1,
    ST_DISABLED = 3'h2,
    ST_ENABLED = 3'h4
  } port_state_t;
endpackage

// ==== verification/port_ctl_regs_assertions.sv ====
// concurrent checks on the port control register bank ports
`timescale 1ns/100ps
module port_ctl_regs_checker #(
  parameter int BOOT_CYC = 20,
  parameter int SANITY_CYC = 40
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register access
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rd_valid,
  // status inputs
  input wire logic sanity_timer_en,
  input wire logic msg_free_empty_set,
  input wire logic rsp_avail_set,
  // port operations
  input wire logic [3:0] cmd_queue_kick,
  input wire logic proc_state_lost,
  input wire logic irq_req,
  input wire logic status_locked,
  input wire logic [2:0] port_state,
  input wire logic [31:0] port_status_reg
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // sanity expiry could overtake a trigger, so most checks need the timer off
  wire logic calm = !sanity_timer_en;
  wire logic wr_init = reg_wr_en && reg_addr == 16'h1044;
  wire logic wr_force = reg_wr_en && reg_addr == 16'h1050;

  a_kick_decode: assert property (
    reg_wr_en && reg_addr >= 16'h1028 && reg_addr <= 16'h1034
    |=> cmd_queue_kick == 4'h1 << ($past(reg_addr[3:2]) - 2'h2)) else $error("queue kick decode wrong");
  a_kick_cause: assert property (
    cmd_queue_kick != 4'h0 |-> $past(reg_wr_en)) else $error("queue kick without write");
  a_read_answer: assert property (
    reg_rd_valid == $past(reg_rd_en)) else $error("read valid not one cycle after read");
  a_wo_read_zero: assert property (
    reg_rd_en && reg_addr >= 16'h1028 && reg_addr <= 16'h1054 |=> reg_rdata == 32'h0) else $error("control read not zero");
  a_init_result: assert property (
    wr_init && calm |=> port_state == 3'h2 && port_status_reg[3] && !port_status_reg[10] && irq_req ##1 status_locked)
    else $error("initialize result wrong");
  a_init_loses: assert property (
    wr_init && calm && port_state == 3'h4 |=> proc_state_lost) else $error("init from enabled kept state");
  a_enable_move: assert property (
    reg_wr_en && reg_addr == 16'h103c && calm && port_state == 3'h2 |=> port_state == 3'h4) else $error("enable failed");
  a_disable_done: assert property (
    reg_wr_en && reg_addr == 16'h1040 && calm && port_state == 3'h4
    |=> port_state == 3'h2 && port_status_reg[2] && irq_req) else $error("disable result wrong");
  a_force_expire: assert property (
    wr_force && sanity_timer_en && port_state != 3'h1
    |=> port_state == 3'h1 && port_status_reg[6] && irq_req && proc_state_lost) else $error("forced expiry missing");
  a_force_ignored: assert property (
    wr_force && calm && port_state != 3'h1 |=> $stable(port_state)) else $error("forced expiry with timer off");
  a_release_clear: assert property (
    reg_wr_en && reg_addr == 16'h1038 && calm && !irq_req && !msg_free_empty_set && !rsp_avail_set
    |=> !status_locked && port_status_reg[1:0] == 2'h0) else $error("status release incomplete");

  c_init: cover property (wr_init);
  c_force: cover property (wr_force && sanity_timer_en);
  c_kick: cover property (cmd_queue_kick == 4'h8);
endmodule

bind port_ctl_regs port_ctl_regs_checker #(.BOOT_CYC(BOOT_CYC), .SANITY_CYC(SANITY_CYC)) chk (
  .clk_sys(clk_sys), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .sanity_timer_en(sanity_timer_en),
  .msg_free_empty_set(msg_free_empty_set), .rsp_avail_set(rsp_avail_set), .cmd_queue_kick(cmd_queue_kick),
  .proc_state_lost(proc_state_lost), .irq_req(irq_req), .status_locked(status_locked), .port_state(port_state),
  .port_status_reg(port_status_reg));

// ==== verification/port_ctl_regs_test.sv ====
// self-checking bench for the port control register bank
`timescale 1ns/100ps
module port_ctl_regs_test;
  localparam int BOOT = 20;
  localparam int SAN = 40;
  logic clk_sys = 0, rst = 1, reg_wr_en = 0, reg_rd_en = 0, sanity_timer_en = 0;
  logic msg_free_empty_set = 0, rsp_avail_set = 0;
  logic [15:0] reg_addr = 0, misc_err_code = 0, structure_fault = 0, irq_dest;
  logic [31:0] reg_wdata = 0, fail_addr = 0, reg_rdata, port_status_reg, w, param;
  logic reg_rd_valid, datagram_free_kick, message_free_kick, proc_state_lost, irq_req, status_locked;
  logic [3:0] cmd_queue_kick, irq_priority;
  logic [2:0] port_state;
  logic [30:0] queue_block_base;
  logic [13:0] irq_vector;
  logic [31:0] expq[$];
  int errors = 0, samples_checked = 0, cycles = 0;

  port_ctl_regs #(.BOOT_CYC(BOOT), .SANITY_CYC(SAN)) dut (
    .clk_sys(clk_sys), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .sanity_timer_en(sanity_timer_en),
    .msg_free_empty_set(msg_free_empty_set), .rsp_avail_set(rsp_avail_set), .misc_err_code(misc_err_code),
    .structure_fault(structure_fault), .fail_addr(fail_addr), .cmd_queue_kick(cmd_queue_kick),
    .datagram_free_kick(datagram_free_kick), .message_free_kick(message_free_kick),
    .proc_state_lost(proc_state_lost), .irq_req(irq_req), .status_locked(status_locked), .port_state(port_state),
    .port_status_reg(port_status_reg), .queue_block_base(queue_block_base), .irq_dest(irq_dest),
    .irq_priority(irq_priority), .irq_vector(irq_vector));

  initial forever #10 clk_sys = ~clk_sys;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one-cycle strobes launched on the falling edge; returns once the effects have landed
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_wr_en = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge clk_sys);
    reg_rd_en = 1;
    reg_addr = a;
    expq.push_back(e);
    @(negedge clk_sys);
    reg_rd_en = 0;
  endtask

  task automatic wait_state(input logic [2:0] s, input int n);
    for (int i = 0; i < n && port_state !== s; i++) @(negedge clk_sys);
    check("port_state", port_state, s);
  endtask

  // read answers are compared in arrival order against the driver's notes
  always @(negedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      conclude();
    end else if (reg_rd_valid === 1'b1) begin
      if (expq.size() == 0) check("unexpected read", 32'h1, 32'h0);
      else check("read data", reg_rdata, expq.pop_front());
    end
  end

  initial begin
    void'($urandom(32'h3a3a));
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 0;
    check("reset state", port_state, 3'h1);
    check("reset status", port_status_reg, 32'h80000400);
    wait_state(3'h2, BOOT + 4);
    check("boot init done", port_status_reg[3], 1'b1);
    misc_err_code = 16'($urandom());
    structure_fault = 16'($urandom());
    fail_addr = $urandom();
    rd(16'h1008, {misc_err_code, structure_fault});
    wr(16'h1008, 32'h0);
    rd(16'h1008, {misc_err_code, structure_fault});
    rd(16'h100c, fail_addr);
    param = {port_ctl_pkg::NODE_COUNT_CODE, port_ctl_pkg::PKT_BUF_LEN, port_ctl_pkg::PARAM_EXT_PRESENT, 1'b0,
      port_ctl_pkg::EXT_ACK_TIMEOUT, port_ctl_pkg::DISABLE_ARB, port_ctl_pkg::EXT_HEADER,
      port_ctl_pkg::QUIET_SLOT_CODE, 8'h00};
    rd(16'h1010, param);
    rd(16'h1014, {port_ctl_pkg::FACTORY_PLANT, port_ctl_pkg::FACTORY_NUMBER});
    rd(16'h1058, {16'h0, port_ctl_pkg::SUBNODE_NUMBER, port_ctl_pkg::STATE_BLOCK_LEN});
    rd(16'h1004, 32'h0);
    w = $urandom();
    wr(16'h1018, w | 32'hffff0000);
    check("irq_dest", irq_dest, w[15:0]);
    rd(16'h1018, {16'h0, w[15:0]});
    wr(16'h1020, w);
    check("irq_priority", irq_priority, w[19:16]);
    check("irq_vector", irq_vector, w[15:2]);
    rd(16'h1020, w & 32'h000ffffc);
    wr(16'h1000, w | 32'h80000000);
    check("queue_block_base", queue_block_base, w[30:0]);
    rd(16'h1000, {1'b0, w[30:0]});
    for (int a = 16'h1028; a <= 16'h1054; a += 4) rd(16'(a), 32'h0);
    // boot irq left the lock taken; free it so the init irq has to take it again
    wr(16'h1038, 32'h0);
    check("lock before init", status_locked, 1'b0);
    wr(16'h1044, $urandom());
    check("init irq", irq_req, 1'b1);
    check("init state", port_state, 3'h2);
    check("init done", port_status_reg[3], 1'b1);
    @(negedge clk_sys);
    check("status lock", status_locked, 1'b1);
    msg_free_empty_set = 1;
    rsp_avail_set = 1;
    @(negedge clk_sys);
    msg_free_empty_set = 0;
    rsp_avail_set = 0;
    // the irq from the sets would win over a release in the same cycle
    @(negedge clk_sys);
    check("flags set", port_status_reg[1:0], 2'h3);
    wr(16'h1038, $urandom());
    check("lock released", status_locked, 1'b0);
    check("flags cleared", port_status_reg[1:0], 2'h0);
    wr(16'h103c, $urandom());
    check("enabled", port_state, 3'h4);
    for (int q = 0; q < 4; q++) begin
      wr(16'(16'h1028 + 4 * q), $urandom());
      check("queue kick", cmd_queue_kick, 4'h1 << q);
    end
    wr(16'h1048, $urandom());
    check("datagram kick", datagram_free_kick, 1'b1);
    wr(16'h104c, $urandom());
    check("message kick", message_free_kick, 1'b1);
    wr(16'h1040, $urandom());
    check("disabled", port_state, 3'h2);
    check("disable irq", irq_req, 1'b1);
    check("disable done", port_status_reg[2], 1'b1);
    wr(16'h103c, 32'h0);
    wr(16'h1044, $urandom());
    check("state lost", proc_state_lost, 1'b1);
    check("init from enabled", port_state, 3'h2);
    wr(16'h1050, $urandom());
    check("force ignored", port_state, 3'h2);
    sanity_timer_en = 1;
    wr(16'h1050, $urandom());
    check("forced expiry", port_state, 3'h1);
    check("expiry flag", port_status_reg[6], 1'b1);
    wr(16'h1044, 32'h0);
    repeat (SAN - 10) @(negedge clk_sys);
    wr(16'h1054, $urandom());
    repeat (SAN - 10) @(negedge clk_sys);
    check("reload held off", port_state, 3'h2);
    wait_state(3'h1, 20);
    sanity_timer_en = 0;
    repeat (3) @(negedge clk_sys);
    conclude();
  end
endmodule
